//--- btsu_pkg.sv
// Behaviour
// - Single swap exchanges aux_reg_4 and temp_reg_0.
// - Pair swap exchanges aux_reg_4/temp_reg_0 and aux_reg_5/temp_reg_1 together.
// - Block swap exchanges aux_reg_4..7 with temp_reg_0..3 in order, together.
// - Bit-pair test uses data-unit ALU for accumulators, address-unit otherwise.
// - Bit-pair test: bit at address to flag one, address+1 to flag two.
// - Accumulator source uses low six address bits; valid 0 to 38.
// - Accumulator address 39: bit 39 to flag one, zero to flag two.
// - Any other out-of-range accumulator address clears both test flags.
// - Register source uses low four address bits; valid 0 to 14.
// - Register address 15: bit 15 to flag one, zero to flag two.
// - Bit-pair test may repeat back to back; tests change no source.
// - Memory bit test, address-unit ALU, bit chosen by register or immediate.
// - Register-selected memory bit uses low four register bits, 0 to 15.
// - Single register test copies a temp register bit to chosen flag.
package btsu_pkg;
   typedef enum logic [2:0] {
      BTSU_OP_NONE = 3'h0,
      BTSU_OP_SWAP = 3'h1,
      BTSU_OP_PAIR = 3'h3,
      BTSU_OP_BLOCK = 3'h2,
      BTSU_OP_BPAIR = 3'h6,
      BTSU_OP_TREG = 3'h7,
      BTSU_OP_TMEM = 3'h5
   } btsu_op_e;
   localparam int unsigned BTSU_DATA_W = 16;
   localparam int unsigned BTSU_ACC_W = 40;
   localparam logic [5:0] BTSU_ACC_LAST = 6'h26;
   localparam logic [5:0] BTSU_ACC_TOP = 6'h27;
   localparam logic [3:0] BTSU_REG_TOP = 4'hf;
   localparam logic [7:0] BTSU_ADR_AUX = 8'h00;
   localparam logic [7:0] BTSU_ADR_TEMP = 8'h10;
   localparam logic [7:0] BTSU_ADR_FLAG = 8'h20;
   localparam int unsigned BTSU_FLAG_ONE_BIT = 0;
   localparam int unsigned BTSU_FLAG_TWO_BIT = 1;
   localparam logic [15:0] BTSU_REG_RESET = 16'h0000;
endpackage

//--- btsu_unit.sv
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module btsu_unit
   import btsu_pkg::*;
#(
   parameter int unsigned ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic op_valid_i,
   input wire logic [2:0] op_code_i,
   input wire logic src_is_acc_i,
   input wire logic [BTSU_ACC_W-1:0] acc_i,
   input wire logic [BTSU_DATA_W-1:0] reg_src_i,
   input wire logic [BTSU_DATA_W-1:0] bit_addr_i,
   input wire logic [1:0] temp_sel_i,
   input wire logic [BTSU_DATA_W-1:0] mem_data_i,
   input wire logic use_imm_i,
   input wire logic [3:0] imm_bit_index_i,
   input wire logic flag_sel_i,
   output logic test_flag_one_o,
   output logic test_flag_two_o,
   output logic du_sel_o,
   output logic done_o
);
   // Decode needs address bits 4:2 plus the flag word at 0x20
   if (ADR_W < 6 || ADR_W > 32) begin : g_adr_w_bad
      $error("btsu_unit: ADR_W must be 6 to 32");
   end

   logic [15:0] aux [4];
   logic [15:0] tmp [4];
   logic [15:0] next_aux [4];
   logic [15:0] next_tmp [4];
   logic flag_one;
   logic flag_two;
   logic next_flag_one;
   logic next_flag_two;
   logic du_sel;
   logic next_du_sel;
   logic done;
   logic next_done;
   logic ack;
   logic next_ack;
   logic [31:0] rdat;
   logic [31:0] next_rdat;

   logic op_go;
   logic wb_req;
   logic wb_wr;
   logic [5:0] acc_addr;
   logic [3:0] reg_addr;
   logic [3:0] mem_idx;
   logic [BTSU_ACC_W-1:0] acc_sh;
   logic [15:0] reg_sh;
   logic pair_one;
   logic pair_two;
   logic single_bit;
   logic [1:0] widx;
   logic [15:0] wval;
   logic wb_in_regs;

   // No busy state, so a held strobe repeats the op every cycle
   assign op_go = op_valid_i;
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack;
   assign wb_wr = wb_req & wb_we_i;
   assign widx = wb_adr_i[3:2];
   // Whole-address compare, so wider buses cannot alias the words
   assign wb_in_regs = wb_adr_i < ADR_W'(BTSU_ADR_FLAG);
   // Only the low 16 bits exist; lanes 2 and 3 are ignored
   assign wval = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                  wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

   assign acc_addr = bit_addr_i[5:0];
   assign reg_addr = bit_addr_i[3:0];
   assign acc_sh = acc_i >> acc_addr;
   assign reg_sh = reg_src_i >> reg_addr;

   // Bit-pair result, out-of-range handling explicit
   always_comb begin
      pair_one = 1'b0;
      pair_two = 1'b0;
      if (src_is_acc_i) begin
         if (acc_addr <= BTSU_ACC_LAST) begin
            pair_one = acc_sh[0];
            pair_two = acc_sh[1];
         end else if (acc_addr == BTSU_ACC_TOP) begin
            pair_one = acc_i[BTSU_ACC_W-1];
            pair_two = 1'b0;
         end else begin
            pair_one = 1'b0;
            pair_two = 1'b0;
         end
      end else begin
         if (reg_addr != BTSU_REG_TOP) begin
            pair_one = reg_sh[0];
            pair_two = reg_sh[1];
         end else begin
            pair_one = reg_src_i[BTSU_DATA_W-1];
            pair_two = 1'b0;
         end
      end
   end

   // Memory index from immediate or low four register bits
   assign mem_idx = use_imm_i ? imm_bit_index_i : reg_src_i[3:0];

   always_comb begin
      single_bit = 1'b0;
      if (op_code_i == BTSU_OP_TMEM) begin
         single_bit = mem_data_i[mem_idx];
      end else begin
         single_bit = tmp[temp_sel_i][reg_addr];
      end
   end

   // Register file: swaps first, bus writes only when no swap
   always_comb begin
      next_aux = aux;
      next_tmp = tmp;
      if (op_go && op_code_i == BTSU_OP_SWAP) begin
         next_aux[0] = tmp[0];
         next_tmp[0] = aux[0];
      end else if (op_go && op_code_i == BTSU_OP_PAIR) begin
         for (int i = 0; i < 2; i++) begin
            next_aux[i] = tmp[i];
            next_tmp[i] = aux[i];
         end
      end else if (op_go && op_code_i == BTSU_OP_BLOCK) begin
         for (int i = 0; i < 4; i++) begin
            next_aux[i] = tmp[i];
            next_tmp[i] = aux[i];
         end
      end else if (wb_wr && wb_in_regs) begin
         if (wb_adr_i[4]) begin
            next_tmp[widx] = wval;
         end else begin
            next_aux[widx] = wval;
         end
      end
   end

   // Test flags; hardware test wins over a same-cycle bus write
   always_comb begin
      next_flag_one = flag_one;
      next_flag_two = flag_two;
      next_du_sel = du_sel;
      next_done = 1'b0;
      if (op_go) begin
         next_done = (op_code_i != BTSU_OP_NONE);
         case (op_code_i)
            BTSU_OP_BPAIR: begin
               next_flag_one = pair_one;
               next_flag_two = pair_two;
               next_du_sel = src_is_acc_i;
            end
            BTSU_OP_TREG, BTSU_OP_TMEM: begin
               next_du_sel = 1'b0;
               if (flag_sel_i) begin
                  next_flag_two = single_bit;
               end else begin
                  next_flag_one = single_bit;
               end
            end
            default: begin
               next_du_sel = du_sel;
            end
         endcase
      end else if (wb_wr && wb_adr_i == ADR_W'(BTSU_ADR_FLAG)) begin
         if (wb_sel_i[0]) begin
            next_flag_one = wb_dat_i[BTSU_FLAG_ONE_BIT];
            next_flag_two = wb_dat_i[BTSU_FLAG_TWO_BIT];
         end
      end
   end

   // Classic Wishbone: ack one cycle after the strobe
   always_comb begin
      next_ack = wb_req;
      next_rdat = 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
         if (wb_in_regs) begin
            next_rdat[15:0] = wb_adr_i[4] ? tmp[widx] : aux[widx];
         end else if (wb_adr_i == ADR_W'(BTSU_ADR_FLAG)) begin
            next_rdat[BTSU_FLAG_ONE_BIT] = flag_one;
            next_rdat[BTSU_FLAG_TWO_BIT] = flag_two;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            aux[i] <= BTSU_REG_RESET;
            tmp[i] <= BTSU_REG_RESET;
         end
         flag_one <= 1'b0;
         flag_two <= 1'b0;
         du_sel <= 1'b0;
         done <= 1'b0;
         ack <= 1'b0;
         rdat <= 32'h0000_0000;
      end else begin
         aux <= next_aux;
         tmp <= next_tmp;
         flag_one <= next_flag_one;
         flag_two <= next_flag_two;
         du_sel <= next_du_sel;
         done <= next_done;
         ack <= next_ack;
         rdat <= next_rdat;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdat;
   assign test_flag_one_o = flag_one;
   assign test_flag_two_o = flag_two;
   assign du_sel_o = du_sel;
   assign done_o = done;

   property p_swap;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_SWAP |=>
         aux[0] == $past(tmp[0]) && tmp[0] == $past(aux[0])
         && aux[1] == $past(aux[1]);
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_pair;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_PAIR |=>
         aux[1] == $past(tmp[1]) && tmp[0] == $past(aux[0])
         && tmp[2] == $past(tmp[2]);
   endproperty
   a_pair: assert property (p_pair) else $error("pair swap wrong");

   property p_block;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BLOCK |=>
         aux[3] == $past(tmp[3]) && tmp[2] == $past(aux[2]);
   endproperty
   a_block: assert property (p_block) else $error("block swap wrong");

   property p_unit;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR |=>
         du_sel_o == $past(src_is_acc_i) && done_o;
   endproperty
   a_unit: assert property (p_unit) else $error("alu choice wrong");

   property p_acc_pair;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && src_is_acc_i
      && bit_addr_i[5:0] <= BTSU_ACC_LAST |=>
         test_flag_one_o == $past(acc_i[bit_addr_i[5:0]])
         && test_flag_two_o == $past(acc_i[bit_addr_i[5:0] + 6'h01]);
   endproperty
   a_acc_pair: assert property (p_acc_pair) else $error("acc pair");

   property p_acc_top;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && src_is_acc_i
      && bit_addr_i[5:0] == BTSU_ACC_TOP |=>
         test_flag_one_o == $past(acc_i[39]) && !test_flag_two_o;
   endproperty
   a_acc_top: assert property (p_acc_top) else $error("acc bit 39");

   property p_oor;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && src_is_acc_i
      && bit_addr_i[5:0] > BTSU_ACC_TOP |=>
         !test_flag_one_o && !test_flag_two_o;
   endproperty
   a_oor: assert property (p_oor) else $error("out of range");

   property p_reg_top;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && !src_is_acc_i
      && bit_addr_i[3:0] == BTSU_REG_TOP |=>
         test_flag_one_o == $past(reg_src_i[15]) && !test_flag_two_o;
   endproperty
   a_reg_top: assert property (p_reg_top) else $error("reg bit 15");

   property p_keep;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && (op_code_i == BTSU_OP_TMEM
      || op_code_i == BTSU_OP_TREG) && flag_sel_i && !wb_wr |=>
         $stable(test_flag_one_o) && $stable(aux[0]) && $stable(tmp[0]);
   endproperty
   a_keep: assert property (p_keep) else $error("other flag moved");

   property p_mem;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_TMEM && !flag_sel_i
      && !use_imm_i |=>
         test_flag_one_o == $past(mem_data_i[reg_src_i[3:0]]);
   endproperty
   a_mem: assert property (p_mem) else $error("memory bit wrong");

   property p_reg_pair;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && !src_is_acc_i
      && bit_addr_i[3:0] != BTSU_REG_TOP |=>
         test_flag_one_o == $past(reg_src_i[bit_addr_i[3:0]])
         && test_flag_two_o == $past(reg_src_i[bit_addr_i[3:0] + 4'h1]);
   endproperty
   a_reg_pair: assert property (p_reg_pair) else $error("reg pair");

   // A bus write in the same cycle may legally move a word
   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_BPAIR && !wb_wr |=>
         $stable(aux[0]) && $stable(aux[1]) && $stable(aux[2])
         && $stable(aux[3]) && $stable(tmp[0]) && $stable(tmp[1])
         && $stable(tmp[2]) && $stable(tmp[3]);
   endproperty
   a_hold: assert property (p_hold) else $error("source moved");

   property p_treg;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_TREG && !flag_sel_i |=>
         test_flag_one_o == $past(tmp[temp_sel_i][bit_addr_i[3:0]]);
   endproperty
   a_treg: assert property (p_treg) else $error("temp bit wrong");

   property p_imm;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && op_code_i == BTSU_OP_TMEM
      && flag_sel_i && use_imm_i |=>
         test_flag_two_o == $past(mem_data_i[imm_bit_index_i]);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate bit");

   property p_keep_two;
      @(posedge clk_i) disable iff (rst_i)
      op_valid_i && (op_code_i == BTSU_OP_TMEM
      || op_code_i == BTSU_OP_TREG) && !flag_sel_i |=>
         $stable(test_flag_two_o);
   endproperty
   a_keep_two: assert property (p_keep_two) else $error("flag moved");
endmodule
`default_nettype wire

//--- btsu_issuer.sv
`timescale 1ns/1ps
`default_nettype none
// Decoder side: one op per issue call; stale fields except reg_src_o show junk, not the old value
module btsu_issuer (
   input wire logic clk_i,
   output logic op_valid_o,
   output logic [2:0] op_code_o,
   output logic [39:0] acc_o,
   output logic [15:0] reg_src_o,
   output logic [15:0] bit_addr_o,
   output logic [15:0] mem_data_o
);
   initial begin
      op_valid_o = 1'b0;
      op_code_o = 3'h0;
      acc_o = 40'h0;
      reg_src_o = 16'h0;
      bit_addr_o = 16'h0;
      mem_data_o = 16'h0;
   end
   task automatic issue(input logic [2:0] c, input logic [39:0] a,
         input logic [15:0] r, input logic [15:0] b, input logic [15:0] m);
      @(posedge clk_i);
      op_valid_o <= 1'b1;
      op_code_o <= c;
      acc_o <= a;
      reg_src_o <= r;
      bit_addr_o <= b;
      mem_data_o <= m;
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      op_code_o <= 3'h0;
      acc_o <= ~a;
      bit_addr_o <= ~b;
      mem_data_o <= ~m;
   endtask
   // Repeat: strobe held two cycles, address steps as a repeat would
   task automatic issue_rpt(input logic [2:0] c, input logic [39:0] a,
         input logic [15:0] b0, input logic [15:0] b1);
      @(posedge clk_i);
      op_valid_o <= 1'b1;
      op_code_o <= c;
      acc_o <= a;
      bit_addr_o <= b0;
      @(posedge clk_i);
      bit_addr_o <= b1;
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      op_code_o <= 3'h0;
      acc_o <= ~a;
      bit_addr_o <= ~b1;
   endtask
endmodule
`default_nettype wire

//--- tb_bit_test_and_swap_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bit_test_and_swap_unit;
   import btsu_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, f1, f2, du, done, ov;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic sa = 1'b0, ui = 1'b0, fs = 1'b0;
   logic [3:0] k = 4'h0;
   logic [1:0] ts = 2'h0;
   logic [2:0] oc;
   logic [39:0] acc;
   logic [15:0] rs, ba, md;
   int fail_count = 0;
   int samples_checked = 0;
   always #5 clk_i = ~clk_i;
   btsu_issuer btsu_issuer_i (.clk_i(clk_i), .op_valid_o(ov), .op_code_o(oc),
      .acc_o(acc), .reg_src_o(rs), .bit_addr_o(ba), .mem_data_o(md));
   btsu_unit btsu_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'h3), .wb_dat_o(rdat), .wb_ack_o(ack), .op_valid_i(ov),
      .op_code_i(oc), .src_is_acc_i(sa), .acc_i(acc), .reg_src_i(rs),
      .bit_addr_i(ba), .temp_sel_i(ts), .mem_data_i(md), .use_imm_i(ui),
      .imm_bit_index_i(k), .flag_sel_i(fs), .test_flag_one_o(f1),
      .test_flag_two_o(f2), .du_sel_o(du), .done_o(done));
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Held until ack is sampled; no fixed latency assumed
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, {16'h0, d}, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic op(input logic [2:0] c, input logic [15:0] r,
         input logic [15:0] b, input logic [15:0] m, input logic [1:0] e);
      @(posedge clk_i);
      btsu_issuer_i.issue(c, 40'he0_1234_0060, r, b, m);
      // Results stand from the op's edge; read them one edge later
      @(posedge clk_i);
      chk({done, f2, f1}, {c != BTSU_OP_NONE, e});
   endtask
   task automatic t_reset();
      rdchk(BTSU_ADR_AUX, 32'h0);
      rdchk(8'h40, 32'h0);
   endtask
   task automatic t_swap();
      logic [15:0] av [4] = '{16'h0200, 16'h0300, 16'h0240, 16'h0400};
      logic [15:0] tv [4] = '{16'h0030, 16'h0200, 16'h3400, 16'h0fd3};
      for (int i = 0; i < 4; i++) begin
         wr(BTSU_ADR_AUX + 8'(4 * i), av[i]);
         wr(BTSU_ADR_TEMP + 8'(4 * i), tv[i]);
      end
      op(BTSU_OP_BLOCK, 16'h0, 16'h0, 16'h0, 2'b00);
      for (int i = 0; i < 4; i++) begin
         rdchk(BTSU_ADR_AUX + 8'(4 * i), {16'h0, tv[i]});
         rdchk(BTSU_ADR_TEMP + 8'(4 * i), {16'h0, av[i]});
      end
      op(BTSU_OP_SWAP, 16'h0, 16'h0, 16'h0, 2'b00);
      rdchk(BTSU_ADR_AUX, 32'h0200);
      rdchk(BTSU_ADR_TEMP, 32'h0030);
      op(BTSU_OP_PAIR, 16'h0, 16'h0, 16'h0, 2'b00);
      rdchk(BTSU_ADR_AUX, 32'h0030);
      rdchk(BTSU_ADR_AUX + 8'h4, 32'h0300);
      rdchk(BTSU_ADR_TEMP + 8'h4, 32'h0200);
   endtask
   task automatic t_bpair();
      sa <= 1'b1;
      op(BTSU_OP_BPAIR, 16'h0, 16'h0026, 16'h0, 2'b11);
      chk(du, 1'b1);
      op(BTSU_OP_BPAIR, 16'h0, 16'h0027, 16'h0, 2'b01);
      op(BTSU_OP_BPAIR, 16'h0, 16'h0028, 16'h0, 2'b00);
      btsu_issuer_i.issue_rpt(BTSU_OP_BPAIR, 40'he0_1234_0060, 16'h0005,
         16'h0027);
      chk({done, f2, f1}, 3'b111);
      @(posedge clk_i);
      chk({done, f2, f1}, 3'b101);
      op(BTSU_OP_BPAIR, 16'h0, 16'h0045, 16'h0, 2'b11);
      sa <= 1'b0;
      op(BTSU_OP_BPAIR, 16'hfe00, 16'h000c, 16'h0, 2'b11);
      chk(du, 1'b0);
      op(BTSU_OP_BPAIR, 16'hfe00, 16'h001c, 16'h0, 2'b11);
      op(BTSU_OP_BPAIR, 16'hfe00, 16'h000f, 16'h0, 2'b01);
   endtask
   task automatic t_tests();
      ui <= 1'b1;
      k <= 4'h9;
      fs <= 1'b1;
      op(BTSU_OP_TMEM, 16'h0, 16'h0, 16'h0200, 2'b11);
      ui <= 1'b0;
      fs <= 1'b0;
      op(BTSU_OP_TMEM, 16'hfff3, 16'h0, 16'hfff7, 2'b10);
      wr(BTSU_ADR_TEMP, 16'hfe00);
      op(BTSU_OP_TREG, 16'h0, 16'h000c, 16'h0, 2'b11);
      fs <= 1'b1;
      op(BTSU_OP_TREG, 16'h0, 16'h0008, 16'h0, 2'b01);
      rdchk(BTSU_ADR_TEMP, 32'hfe00);
      rdchk(BTSU_ADR_FLAG, 32'h1);
      op(BTSU_OP_NONE, 16'h0, 16'h0, 16'h0, 2'b01);
      wr(BTSU_ADR_FLAG, 16'h0002);
      rdchk(BTSU_ADR_FLAG, 32'h2);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_swap();
      t_bpair();
      t_tests();
      summarize();
   end
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
